// >>> shared/umps_pkg.sv
// Contract
// - a rise of ring detect to 1 raises a modem-status event.
// - request-to-send is active low; low means this end can take receive data.
// - modem control bit 1 set drives request-to-send low.
// - request-to-send reads high after any reset.
// - flow state steers request-to-send only with enhanced feature bit 6.
// - combined read/write strobe counts only in 68-style bus mode.
// - 68-style, strobe 1 reads the register chosen by select and address.
// - 68-style, strobe 0 writes bus data to the selected register.
//
// constants and types shared by the modem pin and bus strobe block.
// assumes one clock, synchronous active-high reset.
`default_nettype none

package umps_pkg;

    // ------------------------------------------------------------
    // bus widths and field positions
    // ------------------------------------------------------------
    localparam int UMPS_ADDR_W = 5;
    localparam int UMPS_DATA_W = 8;
    localparam int UMPS_MCR_RTS_BIT = 1;
    localparam int UMPS_EFR_AUTO_RTS_BIT = 6;
    // the separate-strobe mode only decodes three address bits
    localparam logic [4:0] UMPS_ADDR16_MASK = 5'h07;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic UMPS_RTS_N_RST = 1'h1;
    localparam logic UMPS_RING_RST = 1'h1;
    localparam logic UMPS_RX_IDLE = 1'h1;
    localparam logic [7:0] UMPS_DATA_RST = 8'h00;
    localparam logic [4:0] UMPS_ADDR_RST = 5'h00;

    // ------------------------------------------------------------
    // bus access states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        UMPS_BUS_IDLE = 2'h1,
        UMPS_BUS_BUSY = 2'h2
    } umps_bus_state_type;

endpackage : umps_pkg

`default_nettype wire

// >>> design/umps_top.sv
// one channel's ring detect, request-to-send and host bus strobe decode.
// assumes inputs are synchronous to clk; the register file sits outside,
// takes the strobes below and answers reads combinationally on reg_rdata.
`default_nettype none

module umps_top (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // modem pins
    input wire logic ring_detect_in,
    output logic rts_n,
    input wire logic rx_in,
    output logic rx_line,
    // modem events and state towards the status logic
    output logic ring_event,
    output logic ring_present,
    // control bits and flow state from the register file
    input wire logic [umps_pkg::UMPS_DATA_W-1:0] modem_ctrl_reg,
    input wire logic [umps_pkg::UMPS_DATA_W-1:0] enhanced_feature_reg,
    input wire logic rx_room,
    // host bus pins
    input wire logic mode_68,
    input wire logic cs_n,
    input wire logic rw,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [umps_pkg::UMPS_ADDR_W-1:0] addr,
    input wire logic [umps_pkg::UMPS_DATA_W-1:0] bus_data_in,
    output logic [umps_pkg::UMPS_DATA_W-1:0] bus_data_out,
    output logic bus_data_oe,
    // strobes towards the register file
    output logic reg_rd,
    output logic reg_wr,
    output logic [umps_pkg::UMPS_ADDR_W-1:0] reg_addr,
    output logic [umps_pkg::UMPS_DATA_W-1:0] reg_wdata,
    input wire logic [umps_pkg::UMPS_DATA_W-1:0] reg_rdata
);
    import umps_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        umps_bus_state_type bus_state;
        logic is_read;
        logic reg_rd;
        logic reg_wr;
        logic [UMPS_ADDR_W-1:0] reg_addr;
        logic [UMPS_DATA_W-1:0] reg_wdata;
        logic [UMPS_DATA_W-1:0] data_out;
        logic data_oe;
        logic ring_meta;
        logic ring_sync;
        logic ring_prev;
        logic ring_event;
        logic ring_present;
        logic rts_n;
        logic rx_line;
    } umps_state_type;

    umps_state_type q;
    umps_state_type d;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // direction of an access: combined strobe in 68 mode, else read strobe
    function automatic logic umps_is_read(input logic m68, input logic rwv,
                                          input logic rdn);
        umps_is_read = m68 ? rwv : ~rdn;
    endfunction : umps_is_read

    // an access is live while select and (in 16 mode) a strobe are low
    function automatic logic umps_live(input logic m68, input logic csn,
                                       input logic rdn, input logic wrn);
        umps_live = ~csn & (m68 | ~rdn | ~wrn);
    endfunction : umps_live

    logic acc_live;
    logic acc_read;
    logic rts_req;
    logic auto_rts;

    assign acc_live = umps_live(mode_68, cs_n, rd_n, wr_n);
    assign acc_read = umps_is_read(mode_68, rw, rd_n);
    assign rts_req = modem_ctrl_reg[UMPS_MCR_RTS_BIT];
    assign auto_rts = enhanced_feature_reg[UMPS_EFR_AUTO_RTS_BIT];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.reg_rd = 1'h0;
        d.reg_wr = 1'h0;
        // ring detect: two flops, then edge against a third
        d.ring_meta = ring_detect_in;
        d.ring_sync = q.ring_meta;
        d.ring_prev = q.ring_sync;
        d.ring_event = q.ring_sync & ~q.ring_prev;
        d.ring_present = ~q.ring_sync;
        // flow control only gates the request in automatic mode
        if (auto_rts) begin
            d.rts_n = ~(rts_req & rx_room);
        end else begin
            d.rts_n = ~rts_req;
        end
        d.rx_line = rx_in;
        // one strobe per access; the bus must release before the next
        case (q.bus_state)
            UMPS_BUS_IDLE: begin
                d.data_oe = 1'h0;
                if (acc_live) begin
                    d.bus_state = UMPS_BUS_BUSY;
                    d.is_read = acc_read;
                    d.reg_rd = acc_read;
                    d.reg_wr = ~acc_read;
                    d.reg_addr = mode_68 ? addr : (addr & UMPS_ADDR16_MASK);
                    d.reg_wdata = bus_data_in;
                end
            end
            UMPS_BUS_BUSY: begin
                // hold the read value on the pins while the access lasts
                d.data_oe = q.is_read & acc_live;
                d.data_out = q.is_read ? reg_rdata : q.data_out;
                if (!acc_live) begin
                    d.bus_state = UMPS_BUS_IDLE;
                end
            end
            default: begin
                d.bus_state = UMPS_BUS_IDLE;
                d.data_oe = 1'h0;
            end
        endcase
        // synchronous reset: all pins back to their quiet levels
        if (sys_rst) begin
            d.bus_state = UMPS_BUS_IDLE;
            d.is_read = 1'h0;
            d.reg_rd = 1'h0;
            d.reg_wr = 1'h0;
            d.reg_addr = UMPS_ADDR_RST;
            d.reg_wdata = UMPS_DATA_RST;
            d.data_out = UMPS_DATA_RST;
            d.data_oe = 1'h0;
            d.ring_meta = UMPS_RING_RST;
            d.ring_sync = UMPS_RING_RST;
            d.ring_prev = UMPS_RING_RST;
            d.ring_event = 1'h0;
            d.ring_present = 1'h0;
            d.rts_n = UMPS_RTS_N_RST;
            d.rx_line = UMPS_RX_IDLE;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        q <= d;
    end

    // outputs straight from the state flops
    assign rts_n = q.rts_n;
    assign rx_line = q.rx_line;
    assign ring_event = q.ring_event;
    assign ring_present = q.ring_present;
    assign bus_data_out = q.data_out;
    assign bus_data_oe = q.data_oe;
    assign reg_rd = q.reg_rd;
    assign reg_wr = q.reg_wr;
    assign reg_addr = q.reg_addr;
    assign reg_wdata = q.reg_wdata;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking

    sequence s_ring_rise;
        !ring_detect_in ##1 ring_detect_in;
    endsequence

    sequence s_idle_select;
        q.bus_state == UMPS_BUS_IDLE && acc_live;
    endsequence

    chk_ring_event_edge: assert property (
        disable iff (sys_rst) s_ring_rise |-> ##3 ring_event)
        else $error("ring rise gave no event three cycles later");

    chk_ring_event_once: assert property (
        disable iff (sys_rst) ring_event |=> !ring_event)
        else $error("ring event lasted more than one cycle");

    chk_rts_reset_high: assert property (
        sys_rst |=> rts_n)
        else $error("request-to-send not high after reset");

    chk_rts_manual_drive: assert property (
        disable iff (sys_rst) !auto_rts && rts_req |=> !rts_n)
        else $error("manual request did not drive request-to-send low");

    chk_rts_auto_hold: assert property (
        disable iff (sys_rst) auto_rts && !rx_room |=> rts_n)
        else $error("automatic flow did not hold request-to-send high");

    chk_read_strobe_68: assert property (
        disable iff (sys_rst) s_idle_select ##0 mode_68 && rw
        |=> reg_rd && !reg_wr && reg_addr == $past(addr) ##1 !reg_rd)
        else $error("68-style read did not give one read strobe");

    chk_write_strobe_68: assert property (
        disable iff (sys_rst) s_idle_select ##0 mode_68 && !rw
        |=> reg_wr && reg_wdata == $past(bus_data_in)
            && reg_addr == $past(addr))
        else $error("68-style write did not store bus data");

    chk_rw_ignored_16: assert property (
        disable iff (sys_rst)
        !mode_68 && q.bus_state == UMPS_BUS_IDLE && rd_n && wr_n
        |=> !reg_rd && !reg_wr)
        else $error("combined strobe acted outside 68-style mode");

    chk_read_drive: assert property (
        disable iff (sys_rst) reg_rd && acc_live |=> bus_data_oe)
        else $error("read access did not drive the data bus");

endmodule : umps_top

`default_nettype wire

// >>> dv/umps_modem_model.sv
// far-end modem model: drives the ring detect pin and the receive line.
// assumes one clock; the bench asks for ringing and for line traffic.
`default_nettype none

module umps_modem_model (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // requests from the bench
    input wire logic ringing,
    input wire logic tx_on,
    // modem pins
    output logic ring_pin,
    output logic rx_pin
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------
    // pin drive
    // ----------------------------------------
    // pins start idle so the design never sees an unknown level
    initial begin
        ring_pin = 1'b1;
        rx_pin = 1'b1;
    end

    // changes land just after the edge, like a real modem's outputs
    always @(posedge clk) begin
        ring_pin <= #1 ~ringing;
        if (sys_rst || !tx_on) begin
            rx_pin <= #1 1'b1;
        end else begin
            rx_pin <= #1 1'($urandom);
        end
    end
endmodule : umps_modem_model

`default_nettype wire

// >>> dv/test_uart_modem_pins_and_strobe.sv
// self-checking bench for the modem pin and bus strobe block.
// assumes umps_pkg is compiled first; the register file is modelled here.
`default_nettype none

module test_uart_modem_pins_and_strobe;
    timeunit 1ns;
    timeprecision 100ps;
    import umps_pkg::*;

    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk = 0, sys_rst = 1, ringing = 0, tx_on = 0, oe_prev = 0;
    logic rx_seen = 1;
    logic ring_detect_in, rts_n, rx_in, rx_line, ring_event, ring_present;
    logic [7:0] modem_ctrl_reg = 8'h00, enhanced_feature_reg = 8'h00;
    logic rx_room = 0, mode_68 = 1, cs_n = 1, rw = 1, rd_n = 1, wr_n = 1;
    logic [4:0] addr = 5'h00, reg_addr;
    logic [7:0] bus_data_in = 8'h00, bus_data_out, reg_wdata, reg_rdata;
    logic bus_data_oe, reg_rd, reg_wr;
    logic [15:0] exp_q[$];
    int bad_count = 0, comparisons = 0;

    always #4 clk = ~clk;

    // register file answer: a fixed pattern per address
    function automatic logic [7:0] rf_val(input logic [4:0] a);
        return {a, 3'h5} ^ 8'ha5;
    endfunction : rf_val
    assign reg_rdata = rf_val(reg_addr);

    umps_top dut (.*);
    umps_modem_model modem (.clk(clk), .sys_rst(sys_rst), .ringing(ringing),
        .tx_on(tx_on), .ring_pin(ring_detect_in), .rx_pin(rx_in));

    // ----------------------------------------
    // compare and drive tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic pop_chk(input logic [15:0] got);
        if (exp_q.size() == 0) chk(got, 16'hffff);
        else chk(got, exp_q.pop_front());
    endtask : pop_chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // misleading rd_n/wr_n in 68 mode, unused rw in 16 mode
    task automatic access(input logic m68, input logic wr,
                          input logic [4:0] a, input logic [7:0] d);
        logic [4:0] ea;
        ea = m68 ? a : (a & UMPS_ADDR16_MASK);
        mode_68 = m68;
        rw = ~wr;
        rd_n = wr ^ m68;
        wr_n = ~wr ^ m68;
        addr = a;
        bus_data_in = d;
        cs_n = 0;
        // a read is noted twice: its strobe first, then the data on the pins
        if (!wr) exp_q.push_back({3'h3, ea, 8'h00});
        exp_q.push_back(wr ? {3'h0, ea, d} : {3'h1, 5'h00, rf_val(ea)});
        tick(3);
        cs_n = 1;
        rd_n = 1;
        wr_n = 1;
        tick(2);
    endtask : access

    task automatic rts_case(input logic [2:0] s);
        logic want;
        modem_ctrl_reg = 8'($urandom);
        modem_ctrl_reg[UMPS_MCR_RTS_BIT] = s[0];
        enhanced_feature_reg = 8'($urandom);
        enhanced_feature_reg[UMPS_EFR_AUTO_RTS_BIT] = s[1];
        rx_room = s[2];
        tick(2);
        // one-bit local keeps the inversion from widening inside the cast
        want = s[1] ? ~(s[0] & s[2]) : ~s[0];
        chk(16'(rts_n), 16'(want));
    endtask : rts_case

    task automatic ring_case(input int len);
        ringing = 1;
        tick(len);
        if (len > 5) chk(16'(ring_present), 16'h0001);
        exp_q.push_back({3'h2, 13'h0000});
        ringing = 0;
        tick(8);
    endtask : ring_case

    task automatic close_out;
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    // ----------------------------------------
    // result monitor
    // ----------------------------------------
    // sampled at the falling edge, where registered outputs have settled
    always @(negedge clk) begin
        if (reg_wr) pop_chk({3'h0, reg_addr, reg_wdata});
        if (reg_rd) pop_chk({3'h3, reg_addr, 8'h00});
        // receive line is the pin one cycle late; reset forces it idle
        if (!sys_rst) chk(16'(rx_line), 16'(rx_seen));
        rx_seen <= rx_in;
        if (bus_data_oe && !oe_prev) pop_chk({3'h1, 5'h00, bus_data_out});
        if (ring_event) pop_chk({3'h2, 13'h0000});
        oe_prev <= bus_data_oe;
    end

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        #50us;
        bad_count++;
        close_out;
    end

    initial begin
        void'($urandom(7815));
        modem_ctrl_reg = 8'h02;
        tick(16);
        chk(16'(rts_n), 16'h0001);
        chk(16'(rx_line), 16'h0001);
        sys_rst = 0;
        tx_on = 1;
        tick(2);
        for (int i = 0; i < 8; i++) rts_case(3'(i));
        sys_rst = 1;
        tick(2);
        chk(16'(rts_n), 16'h0001);
        sys_rst = 0;
        tick(1);
        for (int i = 0; i < 8; i++) begin
            access(i[0], i[1], 5'($urandom), 8'($urandom));
        end
        // 16 mode with only rw toggling must start no access
        mode_68 = 0;
        rw = 0;
        cs_n = 0;
        tick(3);
        cs_n = 1;
        tick(2);
        ring_case(1);
        ring_case(2);
        ring_case(6);
        chk(16'(exp_q.size()), 16'h0000);
        close_out;
    end
endmodule : test_uart_modem_pins_and_strobe

`default_nettype wire
